// [xbd_decode.sv]
// Peripheral-bus decode, clock latch strobe and transceiver control.
`timescale 1ns/1ps
module xbd_decode
  import xbd_pkg::*;
#(
  parameter int ADDR_W = 16  // Width of the decoded I/O address.
) (
  input  wire logic              clock,                 // System clock, 125 MHz.
  input  wire logic              rst,                   // Asynchronous reset, active high.
  input  wire logic [ADDR_W-1:0] isa_addr,              // ISA address, stable during commands.
  input  wire logic              iow_n,                 // ISA I/O write command, active low.
  input  wire logic              ior_n,                 // ISA I/O read command, active low.
  input  wire logic              memr_n,                // ISA memory read command, active low.
  input  wire logic              memw_n,                // ISA memory write command, active low.
  input  wire logic              dack_n,                // DMA acknowledge, peripheral read.
  input  wire logic              sysclk,                // ISA bus clock.
  input  wire logic              kbd_reset_request_in,  // Keyboard reset request, active low.
  input  wire logic              pci_master,            // Current cycle is PCI-master initiated.
  input  wire logic              rom_space_hit,         // Firmware ROM space decoded.
  input  wire logic              intc_space_hit,        // Interrupt controller space decoded.
  input  wire logic              rom_decode_en,         // Firmware ROM decode enabled.
  input  wire logic              kbd_decode_en,         // Keyboard buffer decode enabled; the select ignores it.
  input  wire logic              clk_decode_en,         // Clock buffer decode enabled; the select ignores it.
  input  wire logic              mc_decode_en,          // Microcontroller decode enabled.
  input  wire logic              prog0_hit,             // Programmable range 0 hit and enabled.
  input  wire logic              prog1_hit,             // Programmable range 1 hit and enabled.
  input  wire logic              ale_as_gpo,            // Latch strobe pin used as spare out.
  input  wire logic              ccs_as_gpo,            // Clock select pin used as spare out.
  input  wire logic              dir_as_gpo,            // Direction pin used as spare out.
  input  wire logic              oe_as_gpo,             // Output enable pin used as spare out.
  input  wire logic [3:0]        spare_value,           // Values for spare outputs 22 to 25.
  output logic                   cpu_init,              // Processor init, active high.
  output logic                   clock_addr_latch_strobe, // Clock address latch / spare 25.
  output logic                   clock_chip_select_n,   // Clock chip select / spare 24.
  output logic                   keyboard_ctrl_select_n, // Keyboard controller select.
  output logic                   micro_ctrl_select_n,   // Microcontroller select.
  output logic                   periph_buffer_direction_n, // Buffer direction / spare 22.
  output logic                   periph_buffer_oe_n     // Buffer output enable / spare 23.
);

  // Synchronised strobes from the pin synchronisers.
  // Every consumer reads these, never the raw command pins.
  xbd_sync_if sig ();

  // All ISA strobes arrive asynchronously and pass two flip-flops first.
  xbd_sync xbd_sync_i (
    .clock                (clock),
    .rst                  (rst),
    .iow_n                (iow_n),
    .ior_n                (ior_n),
    .memr_n               (memr_n),
    .memw_n               (memw_n),
    .dack_n               (dack_n),
    .sysclk               (sysclk),
    .kbd_reset_request_in (kbd_reset_request_in),
    .sig                  (sig)
  );

  // The address pins are asynchronous as well, so they pass two flip-flops.
  // Giving them the same latency as the commands keeps both aligned at the
  // decode; a skew between address bits can only show while it is changing.
  logic [ADDR_W-1:0] addr_meta;  // First address stage, read only by the second.
  logic [ADDR_W-1:0] addr_sync;  // Second address stage, read by the decode.

  // Address synchroniser registers; zero decodes no port.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      addr_meta <= '0;
      addr_sync <= '0;
    end else begin
      addr_meta <= isa_addr;
      addr_sync <= addr_meta;
    end
  end

  // The address comes through its synchroniser, level with the commands.
  wire logic io_cmd    = sig.iow | sig.ior;                   // Any I/O command.
  wire logic mem_cmd   = sig.memr | sig.memw;                 // Any memory command.
  wire logic hit_70    = (addr_sync[15:0] == XBD_PORT_CLK_ADDR);
  wire logic hit_71    = (addr_sync[15:0] == XBD_PORT_CLK_DATA);
  wire logic hit_kbd   = (addr_sync[15:0] == XBD_PORT_KBD_DATA) |
                         (addr_sync[15:0] == XBD_PORT_KBD_CMD);
  wire logic hit_mc    = (addr_sync[15:0] == XBD_PORT_MC_DATA) |
                         (addr_sync[15:0] == XBD_PORT_MC_CMD);

  // Buffer control state, declared before the next-value logic reads it.
  logic periph_oe;  // Internal output enable state, active high.
  logic periph_dir; // Internal read direction state, active high.

  // Chip selects for the fixed peripherals.
  wire logic sel_clk   = io_cmd & hit_71;
  wire logic sel_kbd   = io_cmd & hit_kbd;
  wire logic sel_mc    = io_cmd & hit_mc;

  // A supported peripheral decoded with its decode enabled; others never open the buffer.
  wire logic io_periph  = (hit_kbd & kbd_decode_en) | (hit_71 & clk_decode_en) |
                          (hit_mc & mc_decode_en) | prog0_hit | prog1_hit;
  wire logic rom_en_hit = rom_space_hit & rom_decode_en;
  wire logic oe_decode  = (io_cmd & io_periph) | (mem_cmd & rom_en_hit);

  // PCI cycles release at the command rise; ISA-master cycles hold until the decode ends.
  wire logic oe_isa_hold = ~pci_master & (io_periph | rom_en_hit);
  wire logic next_oe     = oe_decode | (periph_oe & oe_isa_hold);

  // Direction: every I/O read, qualified memory reads, and DMA reads.
  wire logic mem_rd_hit  = rom_space_hit | (pci_master & intc_space_hit);
  wire logic next_dir    = sig.ior | (sig.memr & mem_rd_hit) | sig.dack;

  // Buffer control state; lowered outside reads and after the command or decode ends.
  // Registering the state adds no pin latency, as the pins take the next values; the output flops keep them glitch free.
  // The reset values close the buffer, matching the pin reset levels.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      periph_oe  <= 1'b0;
      periph_dir <= 1'b0;
    end else begin
      periph_oe  <= next_oe;
      periph_dir <= next_dir;
    end
  end

  // Latch strobe sequencer counting sampled SYSCLK rises after the write falls.
  // Counting bus clock rises keeps the strobe tied to SYSCLK at any frequency, but
  // a write that falls between rises gives a strobe up to one period short.
  xbd_ale_state_t ale_state;       // Current sequencer state.
  xbd_ale_state_t next_ale_state;  // Next sequencer state.
  logic [1:0]     ale_count;       // SYSCLK rises seen while strobing.
  logic [1:0]     next_ale_count;  // Next count.

  wire logic ale_start = sig.iow_fall & hit_70;
  wire logic ale_done  = sig.sysclk_rise & (ale_count == XBD_ALE_LEN - 2'h1);

  // Next-state logic; a new write is only taken after the previous one has ended.
  // This ignores the port while the first write is still low, so one
  // command never produces two strobes.
  always_comb begin
    next_ale_state = ale_state;
    next_ale_count = ale_count;
    case (ale_state)
      XBD_ALE_IDLE: begin
        if (ale_start) begin
          next_ale_state = XBD_ALE_HIGH;
          next_ale_count = 2'h0;
        end
      end
      XBD_ALE_HIGH: begin
        if (ale_done) begin
          next_ale_state = XBD_ALE_WAIT;
        end else if (sig.sysclk_rise) begin
          next_ale_count = ale_count + 2'h1;
        end
      end
      XBD_ALE_WAIT: begin
        if (!sig.iow) begin
          next_ale_state = XBD_ALE_IDLE;
        end
      end
      default: begin
        next_ale_state = XBD_ALE_IDLE;
      end
    endcase
  end

  // Sequencer registers.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ale_state <= XBD_ALE_IDLE;
      ale_count <= 2'h0;
    end else begin
      ale_state <= next_ale_state;
      ale_count <= next_ale_count;
    end
  end

  // Pin values before registering; spare-output selection overrides each function.
  // The spare values bypass the decode entirely, so a pin in spare mode
  // ignores every command and still comes from a flip-flop.
  wire logic pin_ale  = ale_as_gpo ? spare_value[3] : (next_ale_state == XBD_ALE_HIGH);
  wire logic pin_ccs  = ccs_as_gpo ? spare_value[2] : ~sel_clk;
  wire logic pin_dir  = dir_as_gpo ? spare_value[0] : ~next_dir;
  wire logic pin_oe   = oe_as_gpo  ? spare_value[1] : ~next_oe;

  // Output flip-flops; reset levels are fixed pin values.
  // The selects and the buffer controls thus lag the synchronised
  // commands by one edge, three edges after the pins.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clock_addr_latch_strobe   <= XBD_RST_ALE;
      clock_chip_select_n       <= XBD_RST_CSN;
      keyboard_ctrl_select_n    <= XBD_RST_CSN;
      micro_ctrl_select_n       <= XBD_RST_CSN;
      periph_buffer_direction_n <= XBD_RST_DIRN;
      periph_buffer_oe_n        <= XBD_RST_OEN;
      cpu_init                  <= 1'b0;
    end else begin
      clock_addr_latch_strobe   <= pin_ale;
      clock_chip_select_n       <= pin_ccs;
      keyboard_ctrl_select_n    <= ~sel_kbd;
      micro_ctrl_select_n       <= ~sel_mc;
      periph_buffer_direction_n <= pin_dir;
      periph_buffer_oe_n        <= pin_oe;
      cpu_init                  <= sig.kbd_reset;
    end
  end

  // Checks on the pin behaviour. Each one looks one edge after its cause,
  // because every pin is registered; spare mode is excluded where the pin
  // no longer carries its function.
  ale_len_a: assert property (@(posedge clock) disable iff (rst)
    (ale_state == XBD_ALE_IDLE && ale_start && !ale_as_gpo) |=> clock_addr_latch_strobe)
    else $error("latch strobe did not rise after port write");
  ale_end_a: assert property (@(posedge clock) disable iff (rst)
    (ale_state == XBD_ALE_HIGH && ale_done && !ale_as_gpo) |=> !clock_addr_latch_strobe)
    else $error("latch strobe did not end after two bus clocks");
  clk_sel_a: assert property (@(posedge clock) disable iff (rst)
    (io_cmd && hit_71 && !ccs_as_gpo) |=> !clock_chip_select_n)
    else $error("clock select missing on port 71h");
  io_read_dir_a: assert property (@(posedge clock) disable iff (rst)
    (sig.ior && !dir_as_gpo) |=> !periph_buffer_direction_n)
    else $error("direction not low on I/O read");
  isa_intc_dir_a: assert property (@(posedge clock) disable iff (rst)
    (sig.memr && !pci_master && !rom_space_hit && !sig.ior && !sig.dack && !dir_as_gpo)
    |=> periph_buffer_direction_n)
    else $error("direction asserted for ISA non-ROM memory read");
  idle_dir_a: assert property (@(posedge clock) disable iff (rst)
    (!sig.ior && !sig.memr && !sig.dack && !dir_as_gpo) |=> periph_buffer_direction_n)
    else $error("direction low outside a read");
  oe_off_a: assert property (@(posedge clock) disable iff (rst)
    (!io_cmd && !mem_cmd && pci_master && !oe_as_gpo) |=> periph_buffer_oe_n)
    else $error("buffer enabled with no command in PCI cycle");
  kbd_sel_a: assert property (@(posedge clock) disable iff (rst)
    (io_cmd && hit_kbd) |=> !keyboard_ctrl_select_n)
    else $error("keyboard select missing");
  mc_sel_a: assert property (@(posedge clock) disable iff (rst)
    (io_cmd && hit_mc) |=> !micro_ctrl_select_n)
    else $error("microcontroller select missing");
  init_a: assert property (@(posedge clock) disable iff (rst)
    sig.kbd_reset |=> cpu_init)
    else $error("processor init not raised");

  ale_c:  cover property (@(posedge clock) disable iff (rst) ale_start);
  dma_c:  cover property (@(posedge clock) disable iff (rst) sig.dack ##1 !sig.dack);
  oe_c:   cover property (@(posedge clock) disable iff (rst) !periph_buffer_oe_n);
  init_c: cover property (@(posedge clock) disable iff (rst) cpu_init);
  spare_c: cover property (@(posedge clock) disable iff (rst) ale_as_gpo && dir_as_gpo);

  // Buffer enable checks. A peripheral whose decode is off, or no peripheral
  // at all, must never see the buffer open; an enabled one opens it one edge
  // after the synchronised command.
  oe_disabled_a: assert property (@(posedge clock) disable iff (rst)
    (!io_periph && !rom_en_hit && !oe_as_gpo) |=> periph_buffer_oe_n)
    else $error("buffer enabled for a disabled or absent peripheral");

  oe_open_a: assert property (@(posedge clock) disable iff (rst)
    (io_cmd && io_periph && !oe_as_gpo) |=> !periph_buffer_oe_n)
    else $error("buffer not enabled for a decoded peripheral");

  // An ISA master keeps the buffer open while its address still decodes, so
  // the enable must survive the end of the command in that case.
  oe_hold_a: assert property (@(posedge clock) disable iff (rst)
    (periph_oe && !pci_master && io_periph && !oe_as_gpo) |=> !periph_buffer_oe_n)
    else $error("buffer closed while the ISA address still decodes");

  // Direction for two of the read kinds not checked above: interrupt controller
  // space for PCI masters, and DMA reads from the peripheral side.
  pci_intc_dir_a: assert property (@(posedge clock) disable iff (rst)
    (sig.memr && pci_master && intc_space_hit && !dir_as_gpo) |=> !periph_buffer_direction_n)
    else $error("direction missing for PCI interrupt space read");

  dma_dir_a: assert property (@(posedge clock) disable iff (rst)
    (sig.dack && !dir_as_gpo) |=> !periph_buffer_direction_n)
    else $error("direction not low during DMA acknowledge");

  // Spare-output mode passes the chosen value through the output flop, so
  // the pin shows last cycle's value whatever the decode is doing.
  spare_ale_a: assert property (@(posedge clock) disable iff (rst)
    ale_as_gpo |=> (clock_addr_latch_strobe == $past(spare_value[3])))
    else $error("latch strobe pin does not follow its spare value");

  spare_dir_a: assert property (@(posedge clock) disable iff (rst)
    dir_as_gpo |=> (periph_buffer_direction_n == $past(spare_value[0])))
    else $error("direction pin does not follow its spare value");

endmodule : xbd_decode

// [xbd_decode_tb.sv]
// Self-checking testbench for the peripheral-bus decode and buffer control block.
`timescale 1ns/1ps
module xbd_decode_tb;
  import xbd_pkg::*;
  logic        clock;                 // System clock, 8 ns period.
  logic        rst;                   // Reset, active high.
  logic        dack_n;                // DMA acknowledge.
  logic        kbd_reset_request_in;  // Keyboard reset request, active low.
  logic        pci_master;            // Cycle owner.
  logic        rom_hit;               // ROM space wanted; decoded only at address 0.
  logic        intc_hit;              // Interrupt controller space decoded.
  logic [3:0]  en;                    // Decode enables: rom, kbd, clk, mc.
  logic [3:0]  gpo;                   // Spare-output selects: ale, ccs, dir, oe.
  logic [3:0]  spare_value;           // Spare output values.
  logic [1:0]  prog;                  // Programmable range hits 1 and 0.
  logic        sysclk;                // ISA bus clock from the far side.
  logic [15:0] isa_addr;              // ISA address from the far side.
  logic [3:0]  cmd_n;                 // ISA commands from the far side.
  logic        ale;                   // Address latch strobe.
  logic        init;                  // Processor init.
  logic        cs_n;                  // Clock select.
  logic        kbd_n;                 // Keyboard select.
  logic        mc_n;                  // Microcontroller select.
  logic        dir_n;                 // Buffer direction.
  logic        oe_n;                  // Buffer output enable.
  logic [6:0]  pins;                  // All outputs in one vector for compact checks.
  int          bad_count;             // Mismatches seen.
  int          samples_checked;       // Comparisons made.
  int          n;                     // Loop and wait counter.
  assign pins = {ale, init, cs_n, kbd_n, mc_n, dir_n, oe_n};

  xbd_isa_side xbd_isa_side_i (.clock(clock), .sysclk(sysclk), .isa_addr(isa_addr),
    .cmd_n(cmd_n));
  xbd_decode xbd_decode_i (.clock(clock), .rst(rst), .isa_addr(isa_addr), .iow_n(cmd_n[1]),
    .ior_n(cmd_n[0]), .memr_n(cmd_n[2]), .memw_n(cmd_n[3]), .dack_n(dack_n),
    .sysclk(sysclk), .kbd_reset_request_in(kbd_reset_request_in), .pci_master(pci_master),
    .rom_space_hit(rom_hit & (isa_addr == 16'h0000)), .intc_space_hit(intc_hit),
    .rom_decode_en(en[3]), .kbd_decode_en(en[2]), .clk_decode_en(en[1]),
    .mc_decode_en(en[0]), .prog0_hit(prog[0]), .prog1_hit(prog[1]),
    .ale_as_gpo(gpo[3]), .ccs_as_gpo(gpo[2]), .dir_as_gpo(gpo[1]),
    .oe_as_gpo(gpo[0]), .spare_value(spare_value), .cpu_init(init),
    .clock_addr_latch_strobe(ale), .clock_chip_select_n(cs_n),
    .keyboard_ctrl_select_n(kbd_n), .micro_ctrl_select_n(mc_n),
    .periph_buffer_direction_n(dir_n), .periph_buffer_oe_n(oe_n));

  // The clock toggles every half period.
  initial clock = 1'b0;
  always #4 clock = ~clock;

  // Compares the masked output bits with what is expected.
  task automatic chk(input string nm, input logic [6:0] e, input logic [6:0] m);
    samples_checked++;
    if ((pins & m) !== (e & m)) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e & m, pins & m);
    end
  endtask : chk

  // One PCI-master cycle: checks while the command is low, then after release.
  task automatic access(input logic [15:0] a, input int c, input logic [6:0] e,
                        input logic [6:0] m);
    xbd_isa_side_i.start(a, c);
    repeat (5) @(negedge clock);
    chk("pins during command", e, m);
    xbd_isa_side_i.stop(c, 1'b1);
    repeat (5) @(negedge clock);
    chk("pins after command", 7'h1f, 7'h7f);
  endtask : access

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  // Each scenario drives inputs at falling edges only.
  initial begin
    bad_count = 0;
    samples_checked = 0;
    rst = 1'b1;
    dack_n = 1'b1;
    kbd_reset_request_in = 1'b1;
    pci_master = 1'b1;
    rom_hit = 1'b0;
    intc_hit = 1'b0;
    en = 4'hf;
    gpo = 4'h0;
    spare_value = 4'h0;
    prog = 2'h0;
    repeat (4) @(negedge clock);
    chk("reset levels", 7'h1f, 7'h7f);
    rst = 1'b0;
    @(negedge clock);
    chk("after reset", 7'h1f, 7'h7f);
    access(16'h0071, 0, 7'h0c, 7'h7f);
    access(16'h0071, 1, 7'h0e, 7'h7f);
    access(16'h0060, 0, 7'h14, 7'h7f);
    access(16'h0064, 1, 7'h16, 7'h7f);
    access(16'h0062, 0, 7'h18, 7'h7f);
    access(16'h0066, 1, 7'h1a, 7'h7f);
    access(16'h0080, 0, 7'h1d, 7'h7f);
    en = 4'h0;
    access(16'h0071, 0, 7'h01, 7'h03);
    en = 4'hf;
    prog = 2'h1;
    access(16'h0300, 0, 7'h1c, 7'h7f);
    prog = 2'h2;
    access(16'h0300, 1, 7'h1e, 7'h7f);
    prog = 2'h0;
    // Memory reads: owner, ROM hit and interrupt space hit against direction.
    for (n = 0; n < 5; n++) begin
      @(negedge clock);
      {pci_master, rom_hit, intc_hit} = 3'(n == 0 ? 6 : n == 1 ? 5 : n == 2 ? 2 : n == 3 ? 1 : 4);
      access(16'h0000, 2, (n < 3) ? 7'h00 : 7'h02, 7'h02);
    end
    {pci_master, rom_hit, intc_hit} = 3'h6;
    access(16'h0000, 3, 7'h02, 7'h03);
    en[3] = 1'b0;
    access(16'h0000, 2, 7'h01, 7'h01);
    {pci_master, rom_hit, intc_hit} = 3'h0;
    en[3] = 1'b1;
    // ISA master keeps the address after the command ends; enable must hold till it drops.
    xbd_isa_side_i.start(16'h0071, 0);
    repeat (5) @(negedge clock);
    chk("isa read", 7'h0c, 7'h7f);
    xbd_isa_side_i.stop(0, 1'b0);
    repeat (5) @(negedge clock);
    chk("isa hold", 7'h02, 7'h03);
    xbd_isa_side_i.drop_addr();
    repeat (5) @(negedge clock);
    chk("isa release", 7'h03, 7'h03);
    pci_master = 1'b1;
    // Latch strobe: bounded wait for the rise, then its length in system clocks.
    xbd_isa_side_i.start(16'h0070, 1);
    for (n = 0; n < 20 && ale !== 1'b1; n++) @(negedge clock);
    chk("strobe rise", 7'h40, 7'h40);
    if (ale !== 1'b1) begin
      conclude();  // The wait ran out; chk has already counted it.
    end
    for (n = 0; n < 60 && ale === 1'b1; n++) @(negedge clock);
    samples_checked++;
    if (n < 11 || n > 26) begin
      bad_count++;
      $display("[ERR] strobe width expected 11 to 26 seen %0d", n);
    end
    if (ale === 1'b1) begin
      conclude();  // The strobe never ended; the width check counted it.
    end
    repeat (30) @(negedge clock);
    chk("single strobe", 7'h00, 7'h40);
    xbd_isa_side_i.stop(1, 1'b1);
    repeat (5) @(negedge clock);
    // DMA read from the peripheral side.
    dack_n = 1'b0;
    repeat (5) @(negedge clock);
    chk("dma dir", 7'h00, 7'h02);
    dack_n = 1'b1;
    repeat (5) @(negedge clock);
    chk("dma end", 7'h02, 7'h02);
    kbd_reset_request_in = 1'b0;
    repeat (5) @(negedge clock);
    chk("init on", 7'h20, 7'h20);
    kbd_reset_request_in = 1'b1;
    repeat (5) @(negedge clock);
    chk("init off", 7'h00, 7'h20);
    // Pins turned into spare outputs follow spare_value.
    gpo = 4'hf;
    spare_value = 4'ha;
    repeat (5) @(negedge clock);
    chk("spare a", 7'h41, 7'h53);
    spare_value = 4'h5;
    repeat (5) @(negedge clock);
    chk("spare 5", 7'h12, 7'h53);
    conclude();
  end

  // A hung run is cut short and counted as a mismatch.
  initial begin
    #200000;
    bad_count++;
    conclude();
  end
endmodule : xbd_decode_tb

// [xbd_isa_side.sv]
// Far-side model: an ISA master that owns the commands and the free-running bus clock.
`timescale 1ns/1ps
module xbd_isa_side (
  input  wire logic        clock,     // System clock, used to time changes.
  output logic             sysclk,    // ISA bus clock, free running.
  output logic [15:0]      isa_addr,  // Address, stable while a command is low.
  output logic [3:0]       cmd_n      // Commands low active: 0 ior, 1 iow, 2 memr, 3 memw.
);
  // Half period of 48 ns gives six system clocks per phase, enough for the synchronisers.
  initial sysclk = 1'b0;
  always #48 sysclk = ~sysclk;
  initial cmd_n = 4'hf;
  initial isa_addr = 16'hffff;

  // Starts a command with its address; both change just after a falling edge.
  task automatic start(input logic [15:0] a, input int c);
    @(negedge clock);
    isa_addr = a;
    cmd_n[c] = 1'b0;
  endtask : start

  // Ends a command; the address is either dropped now or kept for an ISA master.
  task automatic stop(input int c, input logic drop);
    @(negedge clock);
    cmd_n[c] = 1'b1;
    if (drop) begin
      isa_addr = ~isa_addr;  // A released bus does not keep showing the last value.
    end
  endtask : stop

  // Moves the address off the decoded port after a held ISA-master cycle.
  task automatic drop_addr();
    @(negedge clock);
    isa_addr = ~isa_addr;
  endtask : drop_addr
endmodule : xbd_isa_side

// [xbd_pkg.sv]
// Package with constants and types for the peripheral-bus decode and buffer control block.
package xbd_pkg;

  // Fixed I/O port addresses decoded on the ISA address.
  localparam logic [15:0] XBD_PORT_CLK_ADDR = 16'h0070;  // Clock memory address port.
  localparam logic [15:0] XBD_PORT_CLK_DATA = 16'h0071;  // Clock data port.
  localparam logic [15:0] XBD_PORT_KBD_DATA = 16'h0060;  // Keyboard controller data port.
  localparam logic [15:0] XBD_PORT_KBD_CMD  = 16'h0064;  // Keyboard controller command port.
  localparam logic [15:0] XBD_PORT_MC_DATA  = 16'h0062;  // Microcontroller data port.
  localparam logic [15:0] XBD_PORT_MC_CMD   = 16'h0066;  // Microcontroller command port.

  // Address latch strobe length in SYSCLK periods.
  localparam int unsigned XBD_ALE_SYSCLKS = 2;
  localparam logic [1:0]  XBD_ALE_LEN     = 2'h2;

  // Values of the pins during and after reset.
  localparam logic XBD_RST_ALE  = 1'b0;  // Address latch strobe low.
  localparam logic XBD_RST_CSN  = 1'b1;  // Chip selects high.
  localparam logic XBD_RST_DIRN = 1'b1;  // Direction high.
  localparam logic XBD_RST_OEN  = 1'b1;  // Output enable high.

  // States of the address latch strobe sequencer.
  typedef enum logic [1:0] {
    XBD_ALE_IDLE = 2'b00,  // Waiting for a write to the address port.
    XBD_ALE_HIGH = 2'b01,  // Strobe driven, counting SYSCLKs.
    XBD_ALE_WAIT = 2'b10   // Strobe done, waiting for the write to end.
  } xbd_ale_state_t;

endpackage : xbd_pkg

// [xbd_sync.sv]
// Two-stage synchronisers for the ISA strobes and SYSCLK, with edge pulses.
`timescale 1ns/1ps
module xbd_sync
  import xbd_pkg::*;
(
  input  wire logic clock,           // System clock.
  input  wire logic rst,             // Asynchronous reset, active high.
  input  wire logic iow_n,           // ISA I/O write command, active low.
  input  wire logic ior_n,           // ISA I/O read command, active low.
  input  wire logic memr_n,          // ISA memory read command, active low.
  input  wire logic memw_n,          // ISA memory write command, active low.
  input  wire logic dack_n,          // DMA acknowledge for peripheral-bus reads, active low.
  input  wire logic sysclk,          // ISA SYSCLK, sampled as a level.
  input  wire logic kbd_reset_request_in, // Keyboard reset request, active low.
  xbd_sync_if.producer sig           // Synchronised strobes.
);

  // Raw pins gathered so that one generate loop synchronises them all.
  localparam int N = 7;
  wire logic [N-1:0] raw = {~kbd_reset_request_in, sysclk, ~dack_n, ~memw_n,
                            ~memr_n, ~ior_n, ~iow_n};
  logic [N-1:0] meta;  // First stage, read only by the second stage.
  logic [N-1:0] sync;  // Second stage, safe to use.
  logic [N-1:0] last;  // Previous value of the second stage for edges.

  // One synchroniser per pin; the inactive value is used at reset.
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_sync
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          meta[i] <= 1'b0;
          sync[i] <= 1'b0;
          last[i] <= 1'b0;
        end else begin
          meta[i] <= raw[i];
          sync[i] <= meta[i];
          last[i] <= sync[i];
        end
      end
    end
  endgenerate

  assign sig.iow         = sync[0];
  assign sig.ior         = sync[1];
  assign sig.memr        = sync[2];
  assign sig.memw        = sync[3];
  assign sig.dack        = sync[4];
  assign sig.sysclk_rise = sync[5] & ~last[5];
  assign sig.iow_fall    = sync[0] & ~last[0];
  assign sig.kbd_reset   = sync[6];

endmodule : xbd_sync

// [xbd_sync_if.sv]
// Interface carrying the synchronised ISA strobes between the block's modules.
`timescale 1ns/1ps
interface xbd_sync_if;
  logic iow;      // Synchronised I/O write command, active high.
  logic ior;      // Synchronised I/O read command, active high.
  logic memr;     // Synchronised memory read command, active high.
  logic memw;     // Synchronised memory write command, active high.
  logic dack;     // Synchronised DMA acknowledge from the peripheral bus, active high.
  logic sysclk_rise;  // One-cycle pulse on each synchronised SYSCLK rising edge.
  logic iow_fall;     // One-cycle pulse when the write command starts.
  logic kbd_reset;    // Synchronised keyboard reset request, active high.
  modport producer (output iow, ior, memr, memw, dack, sysclk_rise, iow_fall, kbd_reset);
  modport consumer (input  iow, ior, memr, memw, dack, sysclk_rise, iow_fall, kbd_reset);
endinterface : xbd_sync_if
